// file: core/sfph_core.v
// Protect and hold logic of a small serial flash, device side.
// Assumes host-driven pins arrive asynchronously and are oversampled by clk_in.
`include "sfph_defs.vh"
`default_nettype none

module sfph_core #(
  parameter BUSY_CYC = `SFPH_BUSY_US * `SFPH_CLK_MHZ
) (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  // Serial link pins
  input  wire       chip_sel_n_in,
  input  wire       sclk_in,
  input  wire       serial_in,
  output reg        serial_out,
  output reg        serial_oe_out,
  // Hardware control pins
  input  wire       write_guard_n_in,
  input  wire       pause_n_in,
  // Status and event outputs
  output reg        write_latch_out,
  output reg  [1:0] protect_level_out,
  output reg        status_write_disable_out,
  output reg        powerdown_out,
  output reg        busy_out,
  output reg        hold_out,
  output reg        program_go_out,
  output reg        erase_go_out,
  output reg        reject_out
);

  // ****************************************
  // Interface states
  // ****************************************
  localparam ST_STANDBY = 2'h0;
  localparam ST_ACTIVE  = 2'h1;
  localparam ST_IGNORE  = 2'h2;

  // Synchronised pins: {select, pause_n, guard_n, serial_in, sclk}
  wire [4:0] pins_s;
  sfph_sync #(
    .WIDTH    (5)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({~chip_sel_n_in, pause_n_in, write_guard_n_in, serial_in, sclk_in}),
    .sync_out (pins_s)
  );
  wire sel_s   = pins_s[4];
  wire pause_s = pins_s[3];
  wire guard_s = pins_s[2];
  wire sdi_s   = pins_s[1];
  wire sclk_s  = pins_s[0];

  reg  [1:0]  state_ff;
  reg         sclk_d_ff;
  reg         sel_d_ff;
  reg         hold_ff;
  reg  [7:0]  shift_ff;
  reg  [2:0]  bit_cnt_ff;
  reg  [5:0]  byte_cnt_ff;
  reg  [7:0]  opcode_ff;
  reg  [7:0]  stat_data_ff;
  reg         wlat_ff;
  reg  [1:0]  level_ff;
  reg         swd_ff;
  reg         pdown_ff;
  reg  [31:0] busy_cnt_ff;

  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;
  wire sel_fall  = sel_s & ~sel_d_ff;
  wire desel     = ~sel_s & sel_d_ff;
  wire busy      = (busy_cnt_ff != 32'h0);

  // ****************************************
  // Hold detection
  // ****************************************
  // Level-based: pause low with clock low enters, pause high with clock low exits,
  // which also defers both edges until the clock falls.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_ff <= 1'b0;
    end else if (!sel_s) begin
      hold_ff <= 1'b0;
    end else if (!sclk_s) begin
      hold_ff <= ~pause_s;
    end
  end

  // ****************************************
  // Command decode helpers
  // ****************************************
  function is_known;
    input [7:0] op;
    begin
      case (op)
        `SFPH_OP_WR_ENA, `SFPH_OP_WR_DIS, `SFPH_OP_STWR, `SFPH_OP_PROG,
        `SFPH_OP_SECT, `SFPH_OP_BLK_A, `SFPH_OP_BLK_B, `SFPH_OP_CHIP_A,
        `SFPH_OP_CHIP_B, `SFPH_OP_PDOWN, `SFPH_OP_RELEASE, `SFPH_OP_RDSTAT,
        `SFPH_OP_RDDATA, `SFPH_OP_FASTRD, `SFPH_OP_RDID, `SFPH_OP_REMS: is_known = 1'b1;
        default: is_known = 1'b0;
      endcase
    end
  endfunction

  // Opcode at byte count: completed byte becomes opcode when count is zero
  wire [7:0] new_byte  = {shift_ff[6:0], sdi_s};
  wire       byte_done = sclk_rise & ~hold_ff & (bit_cnt_ff == 3'h7) & (state_ff != ST_IGNORE);

  // Length required for a write-type command to execute
  reg [5:0] need_len;
  reg       alters;
  always @* begin
    need_len = 6'h0;
    alters   = 1'b0;
    case (opcode_ff)
      `SFPH_OP_WR_ENA, `SFPH_OP_WR_DIS, `SFPH_OP_PDOWN,
      `SFPH_OP_RELEASE, `SFPH_OP_CHIP_A, `SFPH_OP_CHIP_B: need_len = `SFPH_LEN_OP;
      `SFPH_OP_STWR: need_len = `SFPH_LEN_STWR;
      `SFPH_OP_PROG, `SFPH_OP_SECT, `SFPH_OP_BLK_A, `SFPH_OP_BLK_B: need_len = `SFPH_LEN_ADDR;
      default: need_len = 6'h0;
    endcase
    case (opcode_ff)
      `SFPH_OP_STWR, `SFPH_OP_PROG, `SFPH_OP_SECT, `SFPH_OP_BLK_A,
      `SFPH_OP_BLK_B, `SFPH_OP_CHIP_A, `SFPH_OP_CHIP_B: alters = 1'b1;
      default: alters = 1'b0;
    endcase
  end

  // Program needs at least one data byte beyond the address
  wire len_ok = (bit_cnt_ff == 3'h0) &&
                ((opcode_ff == `SFPH_OP_PROG) ? (byte_cnt_ff > need_len) : (byte_cnt_ff == need_len));
  wire array_cmd = alters & (opcode_ff != `SFPH_OP_STWR);
  wire exec_ok   = (state_ff == ST_ACTIVE) & len_ok & (need_len != 6'h0) & ~busy;

  // ****************************************
  // Interface shift and state machine
  // ****************************************
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff     <= ST_STANDBY;
      sclk_d_ff    <= 1'b0;
      sel_d_ff     <= 1'b0;
      shift_ff     <= 8'h0;
      bit_cnt_ff   <= 3'h0;
      byte_cnt_ff  <= 6'h0;
      opcode_ff    <= 8'h0;
      stat_data_ff <= 8'h0;
    end else begin
      sclk_d_ff <= sclk_s;
      sel_d_ff  <= sel_s;
      if (!sel_s) begin
        state_ff    <= ST_STANDBY;
        bit_cnt_ff  <= 3'h0;
        byte_cnt_ff <= 6'h0;
      end else begin
        if (sel_fall) begin
          state_ff <= ST_ACTIVE;
        end
        // Clock and data are don't-care while held
        if (sclk_rise && !hold_ff && state_ff != ST_IGNORE) begin
          shift_ff   <= new_byte;
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
        if (byte_done) begin
          if (byte_cnt_ff != 6'h3f) begin
            byte_cnt_ff <= byte_cnt_ff + 6'h1;
          end
          if (byte_cnt_ff == 6'h0) begin
            opcode_ff <= new_byte;
            if (!is_known(new_byte)) begin
              state_ff <= ST_IGNORE;
            end else if (pdown_ff && new_byte != `SFPH_OP_RELEASE) begin
              state_ff <= ST_IGNORE;
            end
          end
          if (byte_cnt_ff == 6'h1) begin
            stat_data_ff <= new_byte;
          end
        end
      end
    end
  end

  // ****************************************
  // Write latch, status bits, power-down, busy
  // ****************************************
  // Guard pin locks status bits only when the disable bit is set
  wire locked = swd_ff & ~guard_s;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wlat_ff     <= 1'b0;
      level_ff    <= `SFPH_RST_LEVEL;
      swd_ff      <= `SFPH_RST_SWD;
      pdown_ff    <= 1'b0;
      busy_cnt_ff <= 32'h0;
    end else begin
      if (busy) begin
        busy_cnt_ff <= busy_cnt_ff - 32'h1;
      end
      if (desel && exec_ok) begin
        case (opcode_ff)
          `SFPH_OP_WR_ENA:  wlat_ff <= 1'b1;
          `SFPH_OP_WR_DIS:  wlat_ff <= 1'b0;
          `SFPH_OP_PDOWN:   pdown_ff <= 1'b1;
          `SFPH_OP_RELEASE: pdown_ff <= 1'b0;
          `SFPH_OP_STWR: begin
            if (wlat_ff && !locked) begin
              level_ff    <= {stat_data_ff[`SFPH_ST_LVL_HI], stat_data_ff[`SFPH_ST_LVL_LO]};
              swd_ff      <= stat_data_ff[`SFPH_ST_SWD];
              wlat_ff     <= 1'b0;
              busy_cnt_ff <= BUSY_CYC;
            end
          end
          `SFPH_OP_PROG, `SFPH_OP_SECT, `SFPH_OP_BLK_A, `SFPH_OP_BLK_B,
          `SFPH_OP_CHIP_A, `SFPH_OP_CHIP_B: begin
            if (wlat_ff && level_ff == 2'h0) begin
              wlat_ff     <= 1'b0;
              busy_cnt_ff <= BUSY_CYC;
            end
          end
          default: wlat_ff <= wlat_ff;
        endcase
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Go pulses only for accepted array work, reject pulse for refused commands; status outputs mirror state
  wire start_arr  = desel & exec_ok & array_cmd & wlat_ff & (level_ff == 2'h0);
  wire reject_now = desel & (state_ff == ST_ACTIVE) & (alters | need_len != 6'h0) &
                    ~(exec_ok & (~alters | (wlat_ff & (array_cmd ? level_ff == 2'h0 : ~locked))));
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      serial_out               <= 1'b0;
      serial_oe_out            <= 1'b0;
      write_latch_out          <= 1'b0;
      protect_level_out        <= 2'h0;
      status_write_disable_out <= 1'b0;
      powerdown_out            <= 1'b0;
      busy_out                 <= 1'b0;
      hold_out                 <= 1'b0;
      program_go_out           <= 1'b0;
      erase_go_out             <= 1'b0;
      reject_out               <= 1'b0;
    end else begin
      // Read datapath is outside this block, so the pin never drives
      serial_out               <= 1'b0;
      serial_oe_out            <= 1'b0;
      write_latch_out          <= wlat_ff;
      protect_level_out        <= level_ff;
      status_write_disable_out <= swd_ff;
      powerdown_out            <= pdown_ff;
      busy_out                 <= busy;
      hold_out                 <= hold_ff;
      program_go_out           <= start_arr & (opcode_ff == `SFPH_OP_PROG);
      erase_go_out             <= start_arr & (opcode_ff != `SFPH_OP_PROG);
      reject_out               <= reject_now;
    end
  end

endmodule // sfph_core

`default_nettype wire

// file: core/sfph_defs.vh
// Constants for the serial flash protect and hold block.
// Assumes inclusion by bare name from the design files under core/.
`ifndef SFPH_DEFS_VH
`define SFPH_DEFS_VH

// ****************************************
// Opcodes
// ****************************************
`define SFPH_OP_WR_ENA      8'h06
`define SFPH_OP_WR_DIS      8'h04
`define SFPH_OP_STWR        8'h01
`define SFPH_OP_PROG        8'h02
`define SFPH_OP_SECT        8'h20
`define SFPH_OP_BLK_A       8'h52
`define SFPH_OP_BLK_B       8'hd8
`define SFPH_OP_CHIP_A      8'h60
`define SFPH_OP_CHIP_B      8'hc7
`define SFPH_OP_PDOWN       8'hb9
`define SFPH_OP_RELEASE     8'hab
`define SFPH_OP_RDSTAT      8'h05
`define SFPH_OP_RDDATA      8'h03
`define SFPH_OP_FASTRD      8'h0b
`define SFPH_OP_RDID        8'h9f
`define SFPH_OP_REMS        8'h90

// ****************************************
// Status field positions and reset values
// ****************************************
`define SFPH_ST_LVL_LO      2
`define SFPH_ST_LVL_HI      3
`define SFPH_ST_SWD         7
`define SFPH_RST_LEVEL      2'h0
`define SFPH_RST_SWD        1'h0

// ****************************************
// Command lengths in bytes
// ****************************************
`define SFPH_LEN_OP         6'h01
`define SFPH_LEN_STWR       6'h02
`define SFPH_LEN_ADDR       6'h04

// ****************************************
// Busy time of internal operations
// ****************************************
`define SFPH_BUSY_US        10
`define SFPH_CLK_MHZ        200

`endif

// file: core/sfph_sync.v
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk_in; outputs feed logic only.
`default_nettype none

module sfph_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_in,
  // Pins and synchronised copies
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // ****************************************
  // Per-bit double flop
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // First stage is read only by the second
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
        end else begin
          meta_ff[i] <= async_in[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_ff;

endmodule // sfph_sync

`default_nettype wire

// file: dv/sfph_host.sv
// Host model: drives select, serial clock, data and pause pins.
// Assumes clk_in is the device clock; serial period is 32 clocks.
`default_nettype none
module sfph_host (
  // Clock
  input  wire logic clk_in,
  // Pins
  output var logic  sel_n_out,
  output var logic  sclk_out,
  output var logic  data_out,
  output var logic  pause_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle pins: deselected, clock parked low
  initial begin
    sel_n_out   = 1'b1;
    sclk_out    = 1'b0;
    data_out    = 1'b0;
    pause_n_out = 1'b1;
  end
  // Half a serial period
  task automatic half();
    repeat (16) @(posedge clk_in);
  endtask
  // One frame, MSB first; optional pause before bit hold_at
  task automatic xfer(input logic [39:0] v, input int n, input int hold_at, input bit drop);
    sel_n_out <= 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      if (i == hold_at) begin
        pause_n_out <= 1'b0;
        half();
        sclk_out <= 1'b1;
        data_out <= ~data_out;
        half();
        sclk_out <= 1'b0;
        half();
        if (drop) begin
          sel_n_out <= 1'b1;
          half();
          pause_n_out <= 1'b1;
          half();
          return;
        end
        pause_n_out <= 1'b1;
        half();
      end
      data_out <= v[39-i];
      half();
      sclk_out <= 1'b1;
      half();
      sclk_out <= 1'b0;
    end
    half();
    sel_n_out <= 1'b1;
    data_out  <= ~data_out;
    half();
  endtask
endmodule // sfph_host
`default_nettype wire

// file: dv/sfph_core_properties.sv
// Checker on the ports of the protect and hold core.
// Assumes pin inputs settle through a two-flop synchroniser.
`default_nettype none
module sfph_chk (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       chip_sel_n_in,
  input wire logic       sclk_in,
  input wire logic       serial_oe_out,
  input wire logic       write_guard_n_in,
  input wire logic       pause_n_in,
  input wire logic       write_latch_out,
  input wire logic [1:0] protect_level_out,
  input wire logic       status_write_disable_out,
  input wire logic       powerdown_out,
  input wire logic       busy_out,
  input wire logic       hold_out,
  input wire logic       program_go_out,
  input wire logic       erase_go_out,
  input wire logic       reject_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ****
  // Properties; four clocks of slack cover pin sync
  // ****
  property p_oe_off; !serial_oe_out; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output enabled");
  property p_hold_drop; chip_sel_n_in [*4] |=> !hold_out; endproperty
  a_hold_drop: assert property (p_hold_drop) else $error("hold kept after deselect");
  property p_hold_on; (!pause_n_in && !sclk_in && !chip_sel_n_in) [*5] |-> hold_out; endproperty
  a_hold_on: assert property (p_hold_on) else $error("hold not entered");
  property p_hold_off; (pause_n_in && !sclk_in) [*5] |-> !hold_out; endproperty
  a_hold_off: assert property (p_hold_off) else $error("hold not left");
  property p_go_ok;
    (program_go_out || erase_go_out) |-> $past(write_latch_out, 4) && protect_level_out == 2'h0 && !powerdown_out;
  endproperty
  a_go_ok: assert property (p_go_ok) else $error("go without permission");
  property p_go_clear; (program_go_out || erase_go_out) |-> ##[0:3] !write_latch_out; endproperty
  a_go_clear: assert property (p_go_clear) else $error("latch not cleared");
  property p_go_busy; (program_go_out || erase_go_out) |-> ##[0:3] busy_out; endproperty
  a_go_busy: assert property (p_go_busy) else $error("busy missing");
  property p_rej_keep;
    reject_out |=> ($stable(write_latch_out) && $stable(protect_level_out) && $stable(status_write_disable_out)) [*3];
  endproperty
  a_rej_keep: assert property (p_rej_keep) else $error("reject changed state");
  property p_rej_only; reject_out |-> !program_go_out && !erase_go_out; endproperty
  a_rej_only: assert property (p_rej_only) else $error("reject with go");
  property p_guard;
    (status_write_disable_out && !write_guard_n_in) [*4] |=> $stable(protect_level_out) && $stable(status_write_disable_out);
  endproperty
  a_guard: assert property (p_guard) else $error("locked field changed");
endmodule // sfph_chk
bind sfph_core sfph_chk u_chk (.clk_in, .rst_in, .chip_sel_n_in, .sclk_in, .serial_oe_out, .write_guard_n_in,
  .pause_n_in, .write_latch_out, .protect_level_out, .status_write_disable_out, .powerdown_out, .busy_out,
  .hold_out, .program_go_out, .erase_go_out, .reject_out);
`default_nettype wire

// file: dv/sfph_core_bench.sv
// Self-checking bench for the protect and hold core.
// Assumes the host model drives all serial pins.
`default_nettype none
module sfph_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_in = 1'b1, guard_n = 1'b1;
  logic sel_n, sclk, sdata, pause_n, so, oe, wl, swd, pd, busy, hold, pgo, ego, rej;
  logic [1:0] lvl;
  logic [3:0] n_p = 4'h0, n_e = 4'h0, n_r = 4'h0;
  int error_cnt = 0;
  int comparisons = 0;
  localparam logic [39:0] EN_CMD = 40'h0600000000;
  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;
  // Pulse counters, one-cycle pulses
  always @(posedge clk_in) begin
    if (pgo === 1'b1) n_p <= n_p + 4'h1;
    if (ego === 1'b1) n_e <= n_e + 4'h1;
    if (rej === 1'b1) n_r <= n_r + 4'h1;
  end
  sfph_host host (.clk_in(clk_in), .sel_n_out(sel_n), .sclk_out(sclk), .data_out(sdata), .pause_n_out(pause_n));
  sfph_core #(.BUSY_CYC(20)) uut (.clk_in(clk_in), .rst_in(rst_in), .chip_sel_n_in(sel_n), .sclk_in(sclk),
    .serial_in(sdata), .serial_out(so), .serial_oe_out(oe), .write_guard_n_in(guard_n), .pause_n_in(pause_n),
    .write_latch_out(wl), .protect_level_out(lvl), .status_write_disable_out(swd), .powerdown_out(pd),
    .busy_out(busy), .hold_out(hold), .program_go_out(pgo), .erase_go_out(ego), .reject_out(rej));
  // ****
  // Helpers
  // ****
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [3:0] st();
    return {swd, wl, lvl};
  endfunction
  // Frame then settle; 40 clocks outlast busy
  task automatic cmd(input logic [39:0] v, input int n);
    host.xfer(v, n, -1, 1'b0);
    repeat (40) @(posedge clk_in);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_latch();
    logic [3:0] r0;
    chk("status", 4'h0, st());
    cmd(EN_CMD, 8);
    chk("status", 4'h4, st());
    cmd(40'h0400000000, 8);
    chk("status", 4'h0, st());
    cmd(EN_CMD, 7);
    r0 = n_r;
    cmd(EN_CMD, 9);
    chk("status", 4'h0, st());
    chk("rejects", r0 + 4'h1, n_r);
    $display("test latch done");
  endtask
  task automatic t_ops();
    logic [7:0] op [6] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h02};
    int len [6] = '{32, 32, 32, 8, 8, 40};
    logic [3:0] p0, e0;
    for (int i = 0; i < 6; i++) begin
      p0 = n_p;
      e0 = n_e;
      cmd({op[i], 32'h0}, len[i]);
      chk("go", p0 + e0, n_p + n_e);
      cmd(EN_CMD, 8);
      cmd({op[i], 32'h0}, len[i]);
      chk("program", (i == 5) ? p0 + 4'h1 : p0, n_p);
      chk("go", p0 + e0 + 4'h1, n_p + n_e);
      chk("status", 4'h0, st());
    end
    $display("test ops done");
  endtask
  task automatic t_level();
    logic [3:0] e0;
    for (int lv = 1; lv < 4; lv++) begin
      cmd(EN_CMD, 8);
      cmd({8'h01, 4'h0, lv[1:0], 2'h0, 24'h0}, 16);
      chk("status", {2'h0, lv[1:0]}, st());
      e0 = n_e;
      cmd(EN_CMD, 8);
      cmd(40'h2000000000, 32);
      chk("status", {2'h1, lv[1:0]}, st());
      chk("erase", e0, n_e);
    end
    cmd(40'h0100000000, 16);
    chk("status", 4'h0, st());
    $display("test level done");
  endtask
  task automatic t_guard();
    logic [3:0] r0;
    cmd(EN_CMD, 8);
    host.xfer(40'h0180000000, 16, -1, 1'b0);
    chk("busy", 4'h1, {3'h0, busy});
    repeat (40) @(posedge clk_in);
    chk("busy", 4'h0, {3'h0, busy});
    chk("status", 4'h8, st());
    @(posedge clk_in);
    guard_n <= 1'b0;
    cmd(EN_CMD, 8);
    r0 = n_r;
    cmd(40'h010c000000, 16);
    chk("status", 4'hc, st());
    chk("rejects", r0 + 4'h1, n_r);
    @(posedge clk_in);
    guard_n <= 1'b1;
    cmd(40'h0100000000, 16);
    chk("status", 4'h0, st());
    $display("test guard done");
  endtask
  task automatic t_pd();
    cmd(40'hb900000000, 8);
    chk("powerdown", 4'h1, {3'h0, pd});
    cmd(EN_CMD, 8);
    chk("status", 4'h0, st());
    cmd(40'hab00000000, 8);
    chk("powerdown", 4'h0, {3'h0, pd});
    cmd(40'h5a00000000, 8);
    chk("enable", 4'h0, {3'h0, oe});
    chk("data out", 4'h0, {3'h0, so});
    chk("status", 4'h0, st());
    $display("test powerdown done");
  endtask
  task automatic t_hold();
    host.xfer(EN_CMD, 8, 3, 1'b0);
    repeat (40) @(posedge clk_in);
    chk("status", 4'h4, st());
    cmd(40'h0400000000, 8);
    host.xfer(EN_CMD, 8, 5, 1'b1);
    repeat (40) @(posedge clk_in);
    chk("status", 4'h0, st());
    chk("hold", 4'h0, {3'h0, hold});
    cmd(EN_CMD, 8);
    chk("status", 4'h4, st());
    $display("test hold done");
  endtask
  // Main sequence: five reset cycles then scenarios
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    t_latch();
    t_ops();
    t_level();
    t_guard();
    t_pd();
    t_hold();
    results();
  end
  // Watchdog, about twice the expected run
  initial begin
    #300000;
    error_cnt++;
    results();
  end
endmodule // sfph_core_bench
`default_nettype wire
